// ===== common/pnc_pkg.sv
package pnc_pkg;

  // Timing, figures in their own units, cycle counts derived from the clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int CYC_PER_MS    = 1000000 / CLK_PERIOD_NS;
  localparam int LONG_PRESS_MS = 5000;
  localparam int STEP_MS       = 500;
  localparam int DEBOUNCE_MS   = 20;
  localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CYC_PER_MS;
  localparam int STEP_CYC       = STEP_MS * CYC_PER_MS;
  localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * CYC_PER_MS;

  // Slave list layout: index 0..31 are A slaves, 32..63 B slaves
  localparam int          NSLV      = 64;
  localparam logic [63:0] SLV0_MASK = 64'h0000_0000_0000_0001;
  localparam logic [5:0]  ADDR_ZERO = 6'h00;
  localparam logic [6:0]  MAX_SLAVE_ADDR = 7'h1f;

  // Display codes
  localparam logic [6:0] CODE_DROPOUT = 7'h27;
  localparam logic [6:0] CODE_NO_LEAVE = 7'h50;
  localparam logic [6:0] CODE_GEN_ERR  = 7'h51;
  localparam logic [6:0] CODE_NO_ZERO  = 7'h5a;
  localparam logic [6:0] CODE_BAD_CFG  = 7'h5e;

  // Station address
  localparam logic [6:0] STATION_MIN     = 7'h01;
  localparam logic [6:0] STATION_MAX     = 7'h63;
  localparam logic [6:0] STATION_DEFAULT = 7'h03;

  // Register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LAS_LO = 8'h08;
  localparam logic [7:0] REG_LAS_HI = 8'h0c;
  localparam logic [7:0] REG_HIST   = 8'h10;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int STAT_ENG      = 0;
  localparam int STAT_PRG      = 1;
  localparam int STAT_BLANK    = 2;
  localparam int STAT_FLASH    = 3;
  localparam int STAT_BANK_B   = 4;
  localparam int STAT_STATION  = 8;
  localparam int STAT_VALUE    = 16;
  localparam int HIST_VALID    = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic held;
    logic brief;
    logic long_hold;
  } pnc_key_t;

  typedef struct packed {
    logic       blank;
    logic       flash;
    logic       bank_b;
    logic [6:0] value;
  } pnc_disp_t;

  typedef struct packed {
    logic       req;
    logic [5:0] old_addr;
    logic [5:0] new_addr;
  } pnc_addr_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FREE, ST_ARMED, ST_CLEAR, ST_BUSY, ST_STATION, ST_ERR
  } pnc_state_t;

endpackage

// ===== src/pnc_key.sv
`timescale 1ns/1ns
module pnc_key #(
  parameter int DEB_CYC  = pnc_pkg::DEBOUNCE_CYC,
  parameter int LONG_CYC = pnc_pkg::LONG_PRESS_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              key_n,
  output pnc_pkg::pnc_key_t      ev
);
  import pnc_pkg::*;

  typedef struct packed {
    logic [1:0]  sync;
    logic        stable;
    logic [31:0] deb_cnt;
    logic [31:0] hold_cnt;
    logic        long_seen;
    pnc_key_t    ev;
  } pnc_key_state_t;

  pnc_key_state_t q, n;

  always_comb begin
    n = q;
    n.sync = {q.sync[0], key_n};
    n.ev.brief = 1'b0;
    n.ev.long_hold = 1'b0;
    // Debounce: level must stay changed for the whole window
    if (!q.sync[1] != q.stable) begin
      if (q.deb_cnt == 32'(DEB_CYC - 1)) begin
        n.stable = !q.sync[1];
        n.deb_cnt = '0;
      end else begin
        n.deb_cnt = q.deb_cnt + 32'h1;
      end
    end else begin
      n.deb_cnt = '0;
    end
    if (n.stable && !q.stable) begin
      n.hold_cnt = '0;
      n.long_seen = 1'b0;
    end else if (q.stable && !q.long_seen) begin
      if (q.hold_cnt == 32'(LONG_CYC - 1)) begin
        n.ev.long_hold = 1'b1;
        n.long_seen = 1'b1;
      end else begin
        n.hold_cnt = q.hold_cnt + 32'h1;
      end
    end
    if (!n.stable && q.stable && !q.long_seen) begin
      n.ev.brief = 1'b1;
    end
    n.ev.held = n.stable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.sync <= 2'h3;
    end else begin
      q <= n;
    end
  end

  assign ev = q.ev;

endmodule

// ===== src/pnc_panel.sv
`timescale 1ns/1ns
// Summary of operation
// - Mode key held five seconds enters engineering mode, engineering lamp lit.
// - Engineering display steps detected addresses upward every half second, blank if none.
// - Engineering mode activates every detected slave except address 0.
// - Protected mode exchanges data only with configured slaves.
// - Brief mode press in engineering goes protected, target kept.
// - Long mode press in engineering goes protected and stores actual as target.
// - Engineering mode cannot be left while an address-0 slave is present.
// - Protected mode activates configured slaves whose actual matches target.
// - Protected display blank without misassignment, else shows a misassigned address.
// - Protected set press advances to next higher misassigned address.
// - Last intermittent error is kept, shown on set press, 39 for supply dropout.
// - Engineering brief set press shows next higher unassigned address.
// - Long set selects shown free address flashing; next set programs address-0 slave.
// - Long set on known slave shows 00, clears its address; release resumes cycling.
// - Auto readdress only in protected mode, flag set, at most one missing.
// - Under those conditions lamp lit and address-0 slave gets missing address.
// - Auto readdress suppressed when replacement configuration data differ.
// - Long set flashes misassigned address; brief set assigns it if data match.
// - After readdress show next misassignment, error code on failure, blank when done.
// - Station address ranges 1 to 99, default 3.
// - Set and mode held five seconds shows station; set increments, mode stores.
// - After reset mode is engineering and auto readdress enabled.
// - Displayed values above 31 are codes or the station address, not slave addresses.
module pnc_panel #(
  parameter int DEB_CYC  = pnc_pkg::DEBOUNCE_CYC,
  parameter int LONG_CYC = pnc_pkg::LONG_PRESS_CYC,
  parameter int STEP_CYC = pnc_pkg::STEP_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              mode_key_n,
  input  wire logic              set_key_n,
  input  wire logic [63:0]       det_list,
  input  wire logic [63:0]       cfg_list,
  input  wire logic [63:0]       cfg_match,
  input  wire logic [63:0]       zero_match,
  input  wire logic              supply_drop,
  input  wire logic              cfg_err_evt,
  input  wire logic [5:0]        cfg_err_addr,
  input  wire logic              addr_done,
  input  wire logic [6:0]        addr_err_code,
  output pnc_pkg::pnc_addr_cmd_t addr_cmd,
  output pnc_pkg::pnc_disp_t     disp,
  output logic [63:0]            act_list,
  output logic                   eng_lamp,
  output logic                   prg_lamp,
  output logic                   store_cfg,
  output logic                   store_station,
  output logic [6:0]             station,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import pnc_pkg::*;

  typedef struct packed {
    pnc_state_t    st;
    logic          eng;
    logic          auto_prog;
    logic [5:0]    ptr;
    logic [5:0]    sel;
    logic [31:0]   step_cnt;
    logic [6:0]    err_code;
    logic [6:0]    hist;
    logic          hist_valid;
    logic [6:0]    station;
    logic          store_cfg;
    logic          store_station;
    logic          prg_lamp;
    logic [63:0]   las;
    pnc_addr_cmd_t cmd;
    pnc_disp_t     disp;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
  } pnc_panel_state_t;

  pnc_panel_state_t q, n;
  pnc_key_t         mode_ev;
  pnc_key_t         set_ev;
  logic [63:0]      prot_act;
  logic [63:0]      mis_vec;
  logic [63:0]      miss_vec;
  logic [63:0]      free_vec;
  logic             auto_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Keys

  pnc_key #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_mode_key (
    .aclk    (aclk),
    .aresetn (aresetn),
    .key_n   (mode_key_n),
    .ev      (mode_ev)
  );

  pnc_key #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_set_key (
    .aclk    (aclk),
    .aresetn (aresetn),
    .key_n   (set_key_n),
    .ev      (set_ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Slave list evaluation

  // First set bit above 'from'; with wrap the search runs round to 'from' itself
  function automatic logic [6:0] find_next(input logic [63:0] v, input logic [5:0] from, input logic wrap);
    logic [6:0] r;
    logic [6:0] j;
    r = '0;
    for (int i = NSLV; i >= 1; i--) begin
      j = 7'(from) + 7'(i);
      if ((wrap || !j[6]) && v[j[5:0]]) begin
        r = {1'b1, j[5:0]};
      end
    end
    return r;
  endfunction

  assign prot_act = det_list & cfg_list & cfg_match;
  assign mis_vec  = (det_list | cfg_list) & ~prot_act & ~SLV0_MASK;
  assign miss_vec = cfg_list & ~det_list;
  // Only A addresses are offered as free, address 0 never
  assign free_vec = {32'h0, ~det_list[31:0]} & ~SLV0_MASK;
  assign auto_ok  = !q.eng && q.auto_prog && ((miss_vec & (miss_vec - 64'h1)) == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Mode and display sequencer

  always_comb begin
    logic [6:0] f;
    logic [5:0] from;
    logic       to_station;
    logic       leave;
    logic       leave_store;
    logic       wr_hit;
    logic [7:0] ra;
    logic [7:0] wa;
    f = '0;
    from = '0;
    leave = 1'b0;
    leave_store = 1'b0;
    wr_hit = 1'b0;
    ra = '0;
    wa = '0;
    n = q;
    n.store_cfg = 1'b0;
    n.store_station = 1'b0;
    to_station = (mode_ev.long_hold && set_ev.held) || (set_ev.long_hold && mode_ev.held);

    // Half-second stepping of the engineering display
    if (q.step_cnt == 32'(STEP_CYC - 1)) begin
      n.step_cnt = '0;
      if (q.eng && q.st == ST_IDLE) begin
        f = find_next(det_list, q.ptr, 1'b1);
        if (f[6]) begin
          n.ptr = f[5:0];
        end
      end
    end else begin
      n.step_cnt = q.step_cnt + 32'h1;
    end

    // Keep the protected pointer on a misassigned address
    if (!q.eng && q.st == ST_IDLE && mis_vec != '0 && !mis_vec[q.ptr]) begin
      f = find_next(mis_vec, q.ptr, 1'b1);
      n.ptr = f[5:0];
    end

    // Intermittent error memory; a dropout outranks a plain error
    if (supply_drop) begin
      n.hist = CODE_DROPOUT;
      n.hist_valid = 1'b1;
    end else if (cfg_err_evt) begin
      n.hist = {1'b0, cfg_err_addr};
      n.hist_valid = 1'b1;
    end

    unique case (q.st)
      ST_IDLE, ST_FREE, ST_ARMED: begin
        if (to_station) begin
          n.st = ST_STATION;
        end else if (mode_ev.long_hold) begin
          if (q.eng) begin
            leave = 1'b1;
            leave_store = 1'b1;
          end else begin
            n.eng = 1'b1;
            n.st = ST_IDLE;
          end
        end else if (mode_ev.brief && q.eng) begin
          leave = 1'b1;
        end else if (q.eng) begin
          if (set_ev.brief && q.st == ST_ARMED) begin
            if (!det_list[0]) begin
              n.err_code = CODE_GEN_ERR;
              n.st = ST_ERR;
            end else begin
              n.cmd = '{req: 1'b1, old_addr: ADDR_ZERO, new_addr: q.sel};
              n.st = ST_BUSY;
            end
          end else if (set_ev.brief) begin
            from = (q.st == ST_FREE) ? q.sel : q.ptr;
            f = find_next(free_vec, from, 1'b1);
            if (f[6]) begin
              n.sel = f[5:0];
              n.st = ST_FREE;
            end
          end else if (set_ev.long_hold && q.st == ST_FREE) begin
            n.st = ST_ARMED;
          end else if (set_ev.long_hold && q.st == ST_IDLE && det_list[q.ptr] && q.ptr != ADDR_ZERO) begin
            n.cmd = '{req: 1'b1, old_addr: q.ptr, new_addr: ADDR_ZERO};
            n.st = ST_CLEAR;
          end
        end else begin
          if (set_ev.brief && q.st == ST_ARMED) begin
            if (!det_list[0]) begin
              n.err_code = CODE_NO_ZERO;
              n.st = ST_ERR;
            end else if (!zero_match[q.sel]) begin
              n.err_code = CODE_BAD_CFG;
              n.st = ST_ERR;
            end else begin
              n.cmd = '{req: 1'b1, old_addr: ADDR_ZERO, new_addr: q.sel};
              n.st = ST_BUSY;
            end
          end else if (set_ev.brief) begin
            f = find_next(mis_vec, q.ptr, 1'b0);
            if (f[6]) begin
              n.ptr = f[5:0];
            end else if (q.hist_valid) begin
              n.err_code = q.hist;
              n.st = ST_ERR;
            end
          end else if (set_ev.long_hold && q.st == ST_IDLE && mis_vec[q.ptr]) begin
            n.sel = q.ptr;
            n.st = ST_ARMED;
          end else if (q.st == ST_IDLE && auto_ok && det_list[0] && miss_vec != '0) begin
            f = find_next(miss_vec, 6'h3f, 1'b1);
            if (zero_match[f[5:0]]) begin
              n.sel = f[5:0];
              n.cmd = '{req: 1'b1, old_addr: ADDR_ZERO, new_addr: f[5:0]};
              n.st = ST_BUSY;
            end
          end
        end
      end
      ST_CLEAR: begin
        if (addr_done) begin
          n.cmd.req = 1'b0;
        end
        if (!n.cmd.req && !set_ev.held) begin
          n.st = ST_IDLE;
        end
      end
      ST_BUSY: begin
        if (addr_done) begin
          n.cmd.req = 1'b0;
          if (addr_err_code != '0) begin
            n.err_code = addr_err_code;
            n.st = ST_ERR;
          end else begin
            n.st = ST_IDLE;
          end
        end
      end
      ST_STATION: begin
        if (set_ev.brief) begin
          n.station = (q.station == STATION_MAX) ? STATION_MIN : q.station + 7'h1;
        end else if (mode_ev.brief) begin
          n.store_station = 1'b1;
          n.st = ST_IDLE;
        end
      end
      ST_ERR: begin
        if (set_ev.brief || mode_ev.brief || set_ev.long_hold || mode_ev.long_hold) begin
          n.st = ST_IDLE;
          if (q.err_code == q.hist && !supply_drop && !cfg_err_evt) begin
            n.hist_valid = 1'b0;
          end
        end
      end
    endcase

    if (leave) begin
      if (det_list[0]) begin
        n.err_code = CODE_NO_LEAVE;
        n.st = ST_ERR;
      end else begin
        n.eng = 1'b0;
        n.store_cfg = leave_store;
        n.st = ST_IDLE;
        f = find_next(mis_vec, 6'h3f, 1'b1);
        n.ptr = f[5:0];
      end
    end

    n.las = n.eng ? (det_list & ~SLV0_MASK) : prot_act;
    n.prg_lamp = !n.eng && q.auto_prog && ((miss_vec & (miss_vec - 64'h1)) == '0);

    // Display image; values above the highest slave address are codes or the station address
    n.disp = '{blank: 1'b0, flash: 1'b0, bank_b: 1'b0, value: '0};
    unique case (n.st)
      ST_IDLE: begin
        n.disp.value = {2'b00, n.ptr[4:0]};
        n.disp.bank_b = n.ptr[5];
        n.disp.blank = n.eng ? !det_list[n.ptr] : (mis_vec == '0);
      end
      ST_FREE: begin
        n.disp.value = {2'b00, n.sel[4:0]};
      end
      ST_ARMED, ST_BUSY: begin
        n.disp.value = {2'b00, n.sel[4:0]};
        n.disp.bank_b = n.sel[5];
        n.disp.flash = 1'b1;
      end
      ST_CLEAR: begin
        n.disp.value = {1'b0, ADDR_ZERO};
      end
      ST_STATION: begin
        n.disp.value = n.station;
      end
      ST_ERR: begin
        n.disp.value = n.err_code;
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    if (s_axi_awvalid && q.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_got && n.w_got && !n.bvalid) begin
      wa = {n.awaddr[7:2], 2'b00};
      wr_hit = (wa == REG_CTRL) || (wa == REG_STATUS) || (wa == REG_LAS_LO) ||
               (wa == REG_LAS_HI) || (wa == REG_HIST);
      if (wa == REG_CTRL && n.wstrb[0]) begin
        n.auto_prog = n.wdata[CTRL_AUTO_BIT];
      end
      n.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      n.bvalid = 1'b1;
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      ra = {s_axi_araddr[7:2], 2'b00};
      n.rdata = '0;
      n.rresp = RESP_OKAY;
      unique case (ra)
        REG_CTRL: n.rdata[CTRL_AUTO_BIT] = q.auto_prog;
        REG_STATUS: begin
          n.rdata[STAT_ENG] = q.eng;
          n.rdata[STAT_PRG] = q.prg_lamp;
          n.rdata[STAT_BLANK] = q.disp.blank;
          n.rdata[STAT_FLASH] = q.disp.flash;
          n.rdata[STAT_BANK_B] = q.disp.bank_b;
          n.rdata[STAT_STATION +: 7] = q.station;
          n.rdata[STAT_VALUE +: 7] = q.disp.value;
        end
        REG_LAS_LO: n.rdata = q.las[31:0];
        REG_LAS_HI: n.rdata = q.las[63:32];
        REG_HIST: begin
          n.rdata[6:0] = q.hist;
          n.rdata[HIST_VALID] = q.hist_valid;
        end
        default: n.rresp = RESP_SLVERR;
      endcase
      n.rvalid = 1'b1;
    end
    n.arready = !n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.eng <= 1'b1;
      q.auto_prog <= 1'b1;
      q.station <= STATION_DEFAULT;
      q.disp.blank <= 1'b1;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign addr_cmd      = q.cmd;
  assign disp          = q.disp;
  assign act_list      = q.las;
  assign eng_lamp      = q.eng;
  assign prg_lamp      = q.prg_lamp;
  assign store_cfg     = q.store_cfg;
  assign store_station = q.store_station;
  assign station       = q.station;
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rvalid  = q.rvalid;

endmodule

// ===== sim/pnc_panel_asserts.sv
`timescale 1ns/1ns
module pnc_panel_asserts (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic [63:0]            det_list,
  input wire logic [63:0]            cfg_list,
  input wire logic [63:0]            cfg_match,
  input wire logic                   addr_done,
  input wire pnc_pkg::pnc_addr_cmd_t addr_cmd,
  input wire logic [63:0]            act_list,
  input wire logic                   eng_lamp,
  input wire logic                   prg_lamp,
  input wire logic                   store_cfg,
  input wire logic [6:0]             station
);
  import pnc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  rst_vals_a: assert property ($rose(aresetn) |->
    eng_lamp && station == STATION_DEFAULT) else $error("reset state wrong");
  eng_act_a: assert property ($past(aresetn) && eng_lamp && $past(eng_lamp) |->
    act_list == ($past(det_list) & ~SLV0_MASK)) else $error("engineering activation wrong");
  prot_act_a: assert property ($past(aresetn) && !eng_lamp && !$past(eng_lamp) |->
    (act_list & ~SLV0_MASK) == ($past(det_list & cfg_list & cfg_match) & ~SLV0_MASK))
    else $error("protected activation wrong");
  no_leave_a: assert property (eng_lamp && det_list[0] |=> eng_lamp)
    else $error("left engineering with address 0 present");
  store_pulse_a: assert property (store_cfg |=> !store_cfg && !eng_lamp)
    else $error("store pulse wrong");
  prg_mode_a: assert property (prg_lamp |-> !eng_lamp)
    else $error("programming lamp in engineering");
  station_rng_a: assert property (station >= STATION_MIN && station <= STATION_MAX)
    else $error("station out of range");
  cmd_hold_a: assert property (addr_cmd.req && !addr_done |=> addr_cmd.req && $stable(addr_cmd))
    else $error("command dropped early");
  cmd_end_a: assert property (addr_cmd.req && addr_done |=> !addr_cmd.req)
    else $error("command not ended");
endmodule
bind pnc_panel pnc_panel_asserts u_chk (.*);

// ===== sim/pnc_slaves.sv
`timescale 1ns/1ns
module pnc_slaves (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   load,
  input wire logic [63:0]            load_val,
  input wire pnc_pkg::pnc_addr_cmd_t addr_cmd,
  output logic [63:0]                det_list,
  output logic                       addr_done,
  output logic [6:0]                 addr_err_code
);
  import pnc_pkg::*;
  logic [3:0] wait_cnt;
  // Answers after a few cycles so the held command is really exercised
  always_ff @(posedge aclk) begin
    addr_done <= 1'b0;
    if (!aresetn) begin
      det_list      <= '0;
      wait_cnt      <= '0;
      addr_err_code <= '0;
    end else if (load) begin
      det_list <= load_val;
    end else if (addr_cmd.req && !addr_done) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt == 4'h5) begin
        wait_cnt  <= '0;
        addr_done <= 1'b1;
        if (det_list[addr_cmd.old_addr]) begin
          det_list[addr_cmd.old_addr] <= 1'b0;
          det_list[addr_cmd.new_addr] <= 1'b1;
          addr_err_code <= 7'h00;
        end else begin
          addr_err_code <= 7'h5c;
        end
      end
    end
  end
endmodule

// ===== sim/pnc_panel_tb_top.sv
`timescale 1ns/1ns
module pnc_panel_tb_top;
  import pnc_pkg::*;
  logic          aclk, aresetn, mode_key_n, set_key_n, supply_drop, cfg_err_evt, load;
  logic          addr_done, eng_lamp, prg_lamp, store_cfg, store_station;
  logic [5:0]    cfg_err_addr;
  logic [6:0]    addr_err_code, station;
  logic [63:0]   det_list, cfg_list, cfg_match, zero_match, act_list, load_val;
  pnc_addr_cmd_t addr_cmd;
  pnc_disp_t     disp;
  logic [7:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int            bad_count, checked, stores, st_stores;
  // Short counts keep the run small: debounce 4, long press 50, step 20
  pnc_panel #(.DEB_CYC(4), .LONG_CYC(50), .STEP_CYC(20)) DUT (.*);
  pnc_slaves u_net (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (store_cfg === 1'b1) stores++;
    if (store_station === 1'b1) st_stores++;
  end
  ////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp === er, "write response");
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rresp === er && (s_axi_rdata & m) === e, "read data");
  endtask
  // Keys are held then released; the wait covers sync, debounce and the state update
  task automatic press(input logic m, input logic s, input int n);
    mode_key_n <= ~m;
    set_key_n  <= ~s;
    cyc(n);
    mode_key_n <= 1'b1;
    set_key_n  <= 1'b1;
    cyc(16);
  endtask
  task automatic set_det(input logic [63:0] v);
    load_val <= v;
    load     <= 1'b1;
    cyc(1);
    load     <= 1'b0;
    cyc(2);
  endtask
  task automatic wait_disp(input logic [9:0] e, output int n);
    for (n = 0; n < 2000 && disp !== e; n++) cyc(1);
    chk(n < 2000, "display value not reached");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    axi_rd(REG_CTRL, 32'h1, 32'h1, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h7f01, {17'h0, STATION_DEFAULT, 8'h01}, RESP_OKAY);
    axi_rd(8'h40, 32'hffffffff, 32'h0, RESP_SLVERR);
    axi_wr(8'h44, 32'h0, RESP_SLVERR);
    axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
    axi_rd(REG_CTRL, 32'h1, 32'h0, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
    supply_drop <= 1'b1;
    cyc(1);
    supply_drop <= 1'b0;
    cyc(1);
    axi_rd(REG_HIST, 32'h1ff, {23'h0, 2'b10, CODE_DROPOUT}, RESP_OKAY);
  endtask
  task automatic t_eng;
    int n;
    set_det(64'h0000_0002_0000_0020);
    wait_disp(10'h005, n);
    chk(act_list === 64'h0000_0002_0000_0020, "engineering activation");
    wait_disp(10'h081, n);
    chk(n == 20, "display step timing");
    set_det(64'h21);
    press(1'b1, 1'b0, 12);
    chk(eng_lamp === 1'b1 && disp === {3'b000, CODE_NO_LEAVE}, "left with slave 0");
    press(1'b0, 1'b1, 12);
  endtask
  task automatic t_prot;
    int s0;
    s0 = stores;
    set_det(64'h220);
    press(1'b1, 1'b0, 12);
    chk(eng_lamp === 1'b0 && stores == s0, "brief mode");
    chk(act_list === 64'h0, "unconfigured active");
    chk(disp === 10'h005, "first misassigned");
    press(1'b0, 1'b1, 12);
    chk(disp === 10'h009, "next misassigned");
    cfg_list  <= 64'h220;
    cfg_match <= '1;
    cyc(3);
    chk(act_list === 64'h220, "configured activation");
    press(1'b1, 1'b0, 70);
    chk(eng_lamp === 1'b1, "enter engineering");
    press(1'b1, 1'b0, 70);
    chk(eng_lamp === 1'b0 && stores == s0 + 1, "long mode store");
  endtask
  task automatic t_auto;
    int n;
    set_det(64'h200);
    chk(prg_lamp === 1'b1, "programming lamp");
    set_det(64'h201);
    cyc(30);
    chk(addr_cmd.req === 1'b0, "readdress with wrong data");
    zero_match <= 64'h20;
    for (n = 0; n < 100 && addr_cmd.req !== 1'b1; n++) cyc(1);
    chk(addr_cmd === {1'b1, 6'h00, 6'h05}, "auto readdress");
    for (n = 0; n < 100 && addr_cmd.req !== 1'b0; n++) cyc(1);
    cyc(3);
    chk(act_list === 64'h220, "replacement active");
  endtask
  task automatic t_station;
    press(1'b1, 1'b1, 70);
    chk(disp.value === STATION_DEFAULT, "station shown");
    press(1'b0, 1'b1, 12);
    chk(disp.value === 7'h04, "station step");
    repeat (96) press(1'b0, 1'b1, 12);
    chk(disp.value === STATION_MIN, "station wrap");
    press(1'b1, 1'b0, 12);
    chk(station === STATION_MIN && st_stores == 1, "station stored");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    cyc(30000);
    bad_count++;
    report_and_stop;
  end
  initial begin
    aresetn = 1'b0;
    mode_key_n = 1'b1;
    set_key_n = 1'b1;
    {supply_drop, cfg_err_evt, load, cfg_err_addr, load_val} = '0;
    {cfg_list, cfg_match, zero_match} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    cyc(3);
    aresetn <= 1'b1;
    cyc(2);
    t_regs;
    t_eng;
    t_prot;
    t_auto;
    t_station;
    report_and_stop;
  end
endmodule
